// file: design/wdi_timer.sv
`timescale 1ns/100ps
`default_nettype none
module wdi_timer #(
  parameter int OSC_DIV = wdi_pkg::OSC_DIV
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // internal oscillator tick, one mclk wide
  input  wire logic        osc_tick_i,
  // system side
  output logic             irq_o,
  output logic             sys_reset_o
);

  initial begin
    if (OSC_DIV < 2 || OSC_DIV > 2 ** wdi_pkg::OSC_W) begin
      $error("wdi_timer: OSC_DIV out of range");
    end
  end

  // state
  logic [7:0]               count_r;
  logic [3:0]               clk_sel_r;
  logic                     cnt_wen_r;
  logic                     unlock_r;
  logic                     run_r;
  logic                     rst_stat_r;
  logic                     wrap_r;
  logic                     wrap_armed_r;
  wdi_pkg::wdi_mode_t       mode_r;
  logic                     irq_en_r;
  logic [wdi_pkg::PRE_W-1:0] pre_r;
  logic [wdi_pkg::OSC_W-1:0] osc_cnt_r;
  logic                     osc_div_tick_r;

  // bus decode
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] wd;
  logic       tick;
  logic       wrap_evt;

  assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wr  = acc && wb_we_i && wb_sel_i[0];
  assign rd  = acc && !wb_we_i;
  assign wd  = wb_dat_i[7:0];

  function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  // prescaler tick select
  function automatic logic pre_tick(input logic [3:0] sel,
                                    input logic [wdi_pkg::PRE_W-1:0] pre,
                                    input logic osc);
    logic [wdi_pkg::PRE_W-1:0] m;
    m = '0;
    if (sel[3]) begin
      for (int i = 0; i < wdi_pkg::PRE_W; i++) begin
        m[i] = (i < wdi_pkg::PRE_MIN_LOG + int'(sel[2:0]));
      end
      pre_tick = ((pre & m) == m);
    end else begin
      pre_tick = osc;
    end
  endfunction : pre_tick

  assign tick     = run_r && pre_tick(clk_sel_r, pre_r, osc_div_tick_r);
  assign wrap_evt = tick && (count_r == wdi_pkg::COUNT_MAX);

  // free-running prescaler for divide 64..8192
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // oscillator divide by OSC_DIV
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_cnt_r      <= '0;
      osc_div_tick_r <= 1'b0;
    end else begin
      osc_div_tick_r <= 1'b0;
      if (osc_tick_i) begin
        if (osc_cnt_r == wdi_pkg::OSC_W'(OSC_DIV - 1)) begin
          osc_cnt_r      <= '0;
          osc_div_tick_r <= 1'b1;
        end else begin
          osc_cnt_r <= osc_cnt_r + 1'b1;
        end
      end
    end
  end

  // bus acknowledge, one wait cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // read data, unmapped reads zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= '0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        wdi_pkg::OFS_CLK_SEL: wb_dat_o[7:0] <= {wdi_pkg::RSVD_ONES[7:4], clk_sel_r};
        wdi_pkg::OFS_CTRL1:   wb_dat_o[7:0] <= {1'b1, cnt_wen_r, 1'b1, unlock_r,
                                                1'b1, run_r, 1'b1, rst_stat_r};
        wdi_pkg::OFS_CTRL2:   wb_dat_o[7:0] <= {wrap_r, 1'b1, mode_r, 1'b1, irq_en_r,
                                                wdi_pkg::RSVD_ONES[2:0]};
        wdi_pkg::OFS_COUNT:   wb_dat_o[7:0] <= count_r;
        default:              wb_dat_o      <= '0;
      endcase
    end
  end

  // counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_r <= wdi_pkg::COUNT_RST;
    end else if (wr && hit(wb_adr_i, wdi_pkg::OFS_COUNT) && cnt_wen_r) begin
      count_r <= wd;
    end else if (tick) begin
      count_r <= count_r + 1'b1;
    end
  end

  // clock select
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_sel_r <= wdi_pkg::CLK_SEL_RST;
    end else if (wr && hit(wb_adr_i, wdi_pkg::OFS_CLK_SEL)) begin
      clk_sel_r <= wd[3:0];
    end
  end

  // first control register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_wen_r  <= 1'b0;
      unlock_r   <= 1'b0;
      run_r      <= 1'b0;
      rst_stat_r <= 1'b0;
    end else begin
      if (wr && hit(wb_adr_i, wdi_pkg::OFS_CTRL1)) begin
        if (!wd[wdi_pkg::C1_CNT_MASK]) begin
          cnt_wen_r <= wd[wdi_pkg::C1_CNT_WEN];
        end
        if (!wd[wdi_pkg::C1_UNLK_MASK]) begin
          unlock_r <= wd[wdi_pkg::C1_UNLK];
        end
        if (unlock_r && !wd[wdi_pkg::C1_RUN_MASK]) begin
          run_r <= wd[wdi_pkg::C1_RUN];
        end
        if (unlock_r && !wd[wdi_pkg::C1_RST_MASK] && !wd[wdi_pkg::C1_RST]) begin
          rst_stat_r <= 1'b0;
        end
      end
      if (sys_reset_o) begin
        rst_stat_r <= 1'b1;
      end
    end
  end

  // second control register, mode and enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r   <= wdi_pkg::WDI_MODE_WATCHDOG;
      irq_en_r <= 1'b0;
    end else if (wr && hit(wb_adr_i, wdi_pkg::OFS_CTRL2)) begin
      if (!wd[wdi_pkg::C2_MODE_MASK]) begin
        mode_r <= wdi_pkg::wdi_mode_t'(wd[wdi_pkg::C2_MODE]);
      end
      if (!wd[wdi_pkg::C2_IE_MASK]) begin
        irq_en_r <= wd[wdi_pkg::C2_IE];
      end
    end
  end

  // wrap flag with read-then-write-zero clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrap_r       <= 1'b0;
      wrap_armed_r <= 1'b0;
    end else begin
      if (rd && hit(wb_adr_i, wdi_pkg::OFS_CTRL2) && wrap_r) begin
        wrap_armed_r <= 1'b1;
      end
      if (wr && hit(wb_adr_i, wdi_pkg::OFS_CTRL2) && wrap_armed_r && !wd[wdi_pkg::C2_WRAP]) begin
        wrap_r       <= 1'b0;
        wrap_armed_r <= 1'b0;
      end
      if (sys_reset_o) begin
        wrap_r       <= 1'b0;
        wrap_armed_r <= 1'b0;
      end
      if (wrap_evt) begin
        wrap_r <= 1'b1;
      end
    end
  end

  // internal reset pulse and interrupt request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sys_reset_o <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      sys_reset_o <= wrap_evt && (mode_r == wdi_pkg::WDI_MODE_WATCHDOG);
      irq_o       <= wrap_r && irq_en_r && (mode_r == wdi_pkg::WDI_MODE_INTERVAL);
    end
  end

endmodule : wdi_timer
`default_nettype wire

// file: include/wdi_pkg.sv
package wdi_pkg;
  // register offsets, byte addresses
  localparam logic [3:0] OFS_CLK_SEL = 4'h0;
  localparam logic [3:0] OFS_CTRL1   = 4'h4;
  localparam logic [3:0] OFS_CTRL2   = 4'h8;
  localparam logic [3:0] OFS_COUNT   = 4'hC;
  // guard_ctrl_one fields
  localparam int C1_CNT_MASK   = 7;
  localparam int C1_CNT_WEN    = 6;
  localparam int C1_UNLK_MASK  = 5;
  localparam int C1_UNLK       = 4;
  localparam int C1_RUN_MASK   = 3;
  localparam int C1_RUN        = 2;
  localparam int C1_RST_MASK   = 1;
  localparam int C1_RST        = 0;
  // guard_ctrl_two fields
  localparam int C2_WRAP       = 7;
  localparam int C2_MODE_MASK  = 6;
  localparam int C2_MODE       = 5;
  localparam int C2_IE_MASK    = 4;
  localparam int C2_IE         = 3;
  // reset values, counter wrap value and reserved read-back ones
  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [3:0] CLK_SEL_RST = 4'h0;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  localparam logic [7:0] RSVD_ONES   = 8'hFF;
  // timing counts
  localparam int PRE_W        = 13;
  localparam int PRE_MIN_LOG  = 6;
  localparam int OSC_DIV      = 2048;
  localparam int OSC_W        = 11;
  // operating modes
  typedef enum logic [0:0] {
    WDI_MODE_WATCHDOG = 1'b0,
    WDI_MODE_INTERVAL = 1'b1
  } wdi_mode_t;
endpackage : wdi_pkg

// file: test/wdi_timer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module wdi_timer_checker #(
  parameter int OSC_DIV = 4
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // system side
  input wire logic        osc_tick_i,
  input wire logic        irq_o,
  input wire logic        sys_reset_o
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic rd_ack;
  assign rd_ack = wb_ack_o && !wb_we_i;
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_upper_zero: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_ctrl1_masks: assert property (rd_ack && wb_adr_i == wdi_pkg::OFS_CTRL1 |->
    wb_dat_o[7] && wb_dat_o[5] && wb_dat_o[3] && wb_dat_o[1]) else $error("ctrl1 mask low");
  a_ctrl2_fixed: assert property (rd_ack && wb_adr_i == wdi_pkg::OFS_CTRL2 |->
    wb_dat_o[6] && wb_dat_o[4] && wb_dat_o[2:0] == 3'h7) else $error("ctrl2 fixed bits");
  a_sel_upper: assert property (rd_ack && wb_adr_i == wdi_pkg::OFS_CLK_SEL |->
    wb_dat_o[7:4] == 4'hF) else $error("select upper bits");
  a_reset_pulse: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("reset pulse long");
  a_irq_no_reset: assert property (irq_o |-> !sys_reset_o)
    else $error("reset in interval mode");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_irq: cover property ($rose(irq_o));
  c_reset: cover property (sys_reset_o);
endmodule : wdi_timer_checker
bind wdi_timer wdi_timer_checker #(.OSC_DIV(OSC_DIV)) u_chk (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_tick_i(osc_tick_i), .irq_o(irq_o), .sys_reset_o(sys_reset_o));
`default_nettype wire

// file: test/wdi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module wdi_host_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // device side
  input  wire logic sys_reset_o,
  output logic      osc_tick_i,
  output int        n_rst
);
  logic [1:0] div_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r      <= 2'h0;
      osc_tick_i <= 1'b0;
      n_rst      <= 0;
    end else begin
      div_r      <= div_r + 2'h1;
      osc_tick_i <= (div_r == 2'h3);
      n_rst      <= n_rst + int'(sys_reset_o);
    end
  end
endmodule : wdi_host_model
`default_nettype wire

// file: test/wdi_timer_test.sv
`timescale 1ns/100ps
`default_nettype none
module wdi_timer_test;
  localparam logic [3:0] A_SEL = wdi_pkg::OFS_CLK_SEL;
  localparam logic [3:0] A_C1  = wdi_pkg::OFS_CTRL1;
  localparam logic [3:0] A_C2  = wdi_pkg::OFS_CTRL2;
  localparam logic [3:0] A_CNT = wdi_pkg::OFS_COUNT;
  logic        mclk, rst, cyc, stb, we, ack, osc, irq, srst;
  logic [3:0]  adr, sel;
  logic [31:0] dat, dat_o;
  logic [7:0]  v;
  int          n_fail, checked, cyc_n, n_rst, n, t0;
  wdi_timer #(.OSC_DIV(4)) u_wdi_timer (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .osc_tick_i(osc),
    .irq_o(irq), .sys_reset_o(srst));
  wdi_host_model u_wdi_host_model (.mclk(mclk), .rst(rst), .sys_reset_o(srst), .osc_tick_i(osc), .n_rst(n_rst));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do @(posedge mclk); while (ack !== 1'b1);
    if (!w) chk($sformatf("reg %h", a), dat_o, {24'h00_0000, e});
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    {rst, sel, cyc, stb, we, adr, dat} = {1'b1, 4'hF, 39'h00_0000_0000};
    {n_fail, checked, cyc_n} = '0;
    void'($urandom(55));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    bus(0, A_SEL, 8'h00, 8'hF0);
    bus(0, A_C1, 8'h00, 8'hAA);
    bus(0, A_C2, 8'h00, 8'h57);
    bus(0, A_CNT, 8'h00, 8'h00);
    bus(0, 4'h2, 8'h00, 8'h00);
    bus(1, A_C2, 8'hFF, 8'h00);
    bus(0, A_C2, 8'h00, 8'h57);
    bus(1, A_CNT, 8'h33, 8'h00);
    bus(0, A_CNT, 8'h00, 8'h00);
    bus(1, A_C1, 8'h5A, 8'h00);
    bus(0, A_C1, 8'h00, 8'hFA);
    repeat (4) begin
      v = 8'($urandom);
      bus(1, A_CNT, v, 8'h00);
      bus(0, A_CNT, 8'h00, v);
    end
    $display("test registers done");
    bus(1, A_SEL, 8'h08, 8'h00);
    bus(0, A_SEL, 8'h00, 8'hF8);
    bus(1, A_C2, 8'h2F, 8'h00);
    bus(0, A_C2, 8'h00, 8'h7F);
    bus(1, A_CNT, 8'hFE, 8'h00);
    bus(1, A_C1, 8'hA6, 8'h00);
    bus(0, A_C1, 8'h00, 8'hFE);
    for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge mclk);
    t0 = int'($time);
    chk("irq", 32'(irq), 32'h0000_0001);
    bus(0, A_C2, 8'h00, 8'hFF);
    bus(1, A_C2, 8'h7F, 8'h00);
    repeat (3) @(posedge mclk);
    chk("irq clear", 32'(irq), 32'h0000_0000);
    for (n = 0; n < 17000 && irq !== 1'b1; n++) @(posedge mclk);
    chk("period", 32'((int'($time) - t0) / 10), 32'h0000_4000);
    chk("no reset", 32'(n_rst), 32'h0000_0000);
    $display("test interval done");
    bus(1, A_C1, 8'hA2, 8'h00);
    bus(0, A_C2, 8'h00, 8'hFF);
    bus(1, A_C2, 8'h07, 8'h00);
    bus(0, A_C2, 8'h00, 8'h57);
    bus(1, A_SEL, 8'h00, 8'h00);
    bus(0, A_SEL, 8'h00, 8'hF0);
    bus(1, A_CNT, 8'hFE, 8'h00);
    bus(1, A_C1, 8'hA6, 8'h00);
    for (n = 0; n < 400 && n_rst == 0; n++) @(posedge mclk);
    chk("wd reset", 32'(n_rst), 32'h0000_0001);
    bus(0, A_C1, 8'h00, 8'hFF);
    bus(0, A_C2, 8'h00, 8'h57);
    $display("test watchdog done");
    complete_run();
  end
endmodule : wdi_timer_test
`default_nettype wire
